// >>> rtl/tmrpo_consts.vh
// register offsets, field positions and reset values of the overflow timer
`ifndef TMRPO_CONSTS_VH
`define TMRPO_CONSTS_VH

// -----------------------------------------------------------------
// register byte addresses
// -----------------------------------------------------------------
`define TMRPO_ADDR_COUNT_LOW 12'h000
`define TMRPO_ADDR_COUNT_HIGH 12'h004
`define TMRPO_ADDR_INT_CONTROL 12'h008
`define TMRPO_ADDR_TIMER_CONTROL 12'h00c
`define TMRPO_ADDR_IRQ_STATUS 12'h010
`define TMRPO_ADDR_IRQ_MASK 12'h014

// -----------------------------------------------------------------
// timer_control fields
// -----------------------------------------------------------------
`define TMRPO_TC_ON 7
`define TMRPO_TC_WIDTH 6
`define TMRPO_TC_BYPASS_N 3
`define TMRPO_TC_RATIO_HI 2
`define TMRPO_TC_RATIO_LO 0
`define TMRPO_TC_WMASK 8'hcf
`define TMRPO_TC_RESET 8'hff

// -----------------------------------------------------------------
// interrupt_control fields
// -----------------------------------------------------------------
`define TMRPO_IC_ENABLE 5
`define TMRPO_IC_FLAG 2
`define TMRPO_IC_WMASK 8'h24
`define TMRPO_IC_RESET 8'h00

// -----------------------------------------------------------------
// event status bits
// -----------------------------------------------------------------
`define TMRPO_EV_OVERFLOW 0
`define TMRPO_EV_WIDTH 1

`endif

// >>> rtl/tmrpo_timer.v
// timer with prescaler, 8/16-bit count, overflow flag and apb register file
`timescale 1ns/1ps
`include "tmrpo_consts.vh"

module tmrpo_timer
(
    // apb slave
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // count source and power state
    input wire count_tick,
    input wire sleep_mode,
    // interrupt and status
    output reg timer_irq,
    output reg tmr_request
);

// -----------------------------------------------------------------
// registers
// -----------------------------------------------------------------
reg [7:0] timer_count_low;
reg [7:0] timer_count_high;
reg [7:0] timer_control;
reg timer_overflow_enable;
reg timer_overflow_flag;
reg [`TMRPO_EV_WIDTH-1:0] irq_status;
reg [`TMRPO_EV_WIDTH-1:0] irq_mask;
reg [7:0] prescale_count;

wire timer_on = timer_control[`TMRPO_TC_ON];
wire timer_width_select = timer_control[`TMRPO_TC_WIDTH];
wire prescaler_bypass_n = timer_control[`TMRPO_TC_BYPASS_N];
wire [2:0] prescale_ratio_select = timer_control[`TMRPO_TC_RATIO_HI:`TMRPO_TC_RATIO_LO];

// -----------------------------------------------------------------
// bus decode
// -----------------------------------------------------------------
// zero-wait slave: setup, access with pready high in the same cycle
wire access = psel && penable && pready;
wire wr = access && pwrite;
wire rd = access && !pwrite;
wire wr_low = wr && (paddr == `TMRPO_ADDR_COUNT_LOW);
wire wr_high = wr && (paddr == `TMRPO_ADDR_COUNT_HIGH);
wire wr_ic = wr && (paddr == `TMRPO_ADDR_INT_CONTROL);
wire wr_tc = wr && (paddr == `TMRPO_ADDR_TIMER_CONTROL);
wire wr_mask = wr && (paddr == `TMRPO_ADDR_IRQ_MASK);
wire rd_status = rd && (paddr == `TMRPO_ADDR_IRQ_STATUS);

// -----------------------------------------------------------------
// address map
// -----------------------------------------------------------------
// unmapped offsets answer with pslverr and read as zero
reg mapped;

always @*
begin
    mapped = 1'b0;
    case (paddr)
        `TMRPO_ADDR_COUNT_LOW:
        begin
            mapped = 1'b1;
        end
        `TMRPO_ADDR_COUNT_HIGH:
        begin
            mapped = 1'b1;
        end
        `TMRPO_ADDR_INT_CONTROL:
        begin
            mapped = 1'b1;
        end
        `TMRPO_ADDR_TIMER_CONTROL:
        begin
            mapped = 1'b1;
        end
        `TMRPO_ADDR_IRQ_STATUS:
        begin
            mapped = 1'b1;
        end
        `TMRPO_ADDR_IRQ_MASK:
        begin
            mapped = 1'b1;
        end
        default:
        begin
            mapped = 1'b0;
        end
    endcase
end

// -----------------------------------------------------------------
// prescaler and count step
// -----------------------------------------------------------------
// sleep freezes the tick entirely, so no overflow can arise to wake the core
wire tick_ok = count_tick && timer_on && !sleep_mode;
wire [7:0] ratio_mask = (8'h02 << prescale_ratio_select) - 8'h01;
wire pre_wrap = (prescale_count & ratio_mask) == ratio_mask;
wire step = tick_ok && (prescaler_bypass_n || pre_wrap);
wire [15:0] full_count = {timer_count_high, timer_count_low};
wire wrap8 = step && !timer_width_select && (timer_count_low == 8'hff);
wire wrap16 = step && timer_width_select && (full_count == 16'hffff);
wire overflow = wrap8 || wrap16;
wire [15:0] next_count = full_count + 16'h0001;

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        prescale_count <= 8'h00;
    end
    else if ((wr_low || wr_high) && !prescaler_bypass_n)
    begin
        prescale_count <= 8'h00;
    end
    else if (tick_ok && !prescaler_bypass_n)
    begin
        prescale_count <= pre_wrap ? 8'h00 : prescale_count + 8'h01;
    end
end

// -----------------------------------------------------------------
// count registers
// -----------------------------------------------------------------
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        timer_count_low <= 8'h00;
        timer_count_high <= 8'h00;
    end
    else
    begin
        if (wr_low)
        begin
            timer_count_low <= pwdata[7:0];
        end
        else if (step)
        begin
            timer_count_low <= next_count[7:0];
        end
        if (wr_high)
        begin
            timer_count_high <= pwdata[7:0];
        end
        else if (step && timer_width_select)
        begin
            timer_count_high <= next_count[15:8];
        end
    end
end

// -----------------------------------------------------------------
// next flag, enable, mask and status
// -----------------------------------------------------------------
// outputs are built from next values, so a write shows on timer_irq
// and tmr_request at the very edge that takes it, with no stale cycle
reg next_enable;
reg next_flag;
reg [`TMRPO_EV_WIDTH-1:0] next_mask;
reg [`TMRPO_EV_WIDTH-1:0] next_status;

always @*
begin
    next_enable = timer_overflow_enable;
    if (wr_ic)
    begin
        next_enable = pwdata[`TMRPO_IC_ENABLE];
    end
    // set beats a simultaneous software clear
    next_flag = timer_overflow_flag;
    if (overflow)
    begin
        next_flag = 1'b1;
    end
    else if (wr_ic)
    begin
        next_flag = pwdata[`TMRPO_IC_FLAG];
    end
    next_mask = irq_mask;
    if (wr_mask)
    begin
        next_mask = pwdata[`TMRPO_EV_WIDTH-1:0];
    end
    next_status = irq_status;
    if (overflow)
    begin
        next_status[`TMRPO_EV_OVERFLOW] = 1'b1;
    end
    else if (rd_status)
    begin
        next_status = {`TMRPO_EV_WIDTH{1'b0}};
    end
end

// -----------------------------------------------------------------
// control and flag
// -----------------------------------------------------------------
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        timer_control <= `TMRPO_TC_RESET;
        timer_overflow_enable <= 1'b0;
        timer_overflow_flag <= 1'b0;
        irq_mask <= {`TMRPO_EV_WIDTH{1'b0}};
    end
    else
    begin
        if (wr_tc)
        begin
            // count writes never touch this register
            timer_control <= pwdata[7:0] & `TMRPO_TC_WMASK;
        end
        timer_overflow_enable <= next_enable;
        timer_overflow_flag <= next_flag;
        irq_mask <= next_mask;
    end
end

// -----------------------------------------------------------------
// sticky event status, cleared on read
// -----------------------------------------------------------------
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        irq_status <= {`TMRPO_EV_WIDTH{1'b0}};
        timer_irq <= 1'b0;
        tmr_request <= 1'b0;
    end
    else
    begin
        irq_status <= next_status;
        timer_irq <= |(next_status & next_mask);
        tmr_request <= next_flag && next_enable;
    end
end

// -----------------------------------------------------------------
// read data select
// -----------------------------------------------------------------
// chosen in the setup cycle, so prdata stands registered in the access cycle
reg [31:0] next_rdata;

always @*
begin
    next_rdata = 32'h00000000;
    if (psel && !penable && !pwrite)
    begin
        case (paddr)
            `TMRPO_ADDR_COUNT_LOW: next_rdata = {24'h000000, timer_count_low};
            `TMRPO_ADDR_COUNT_HIGH: next_rdata = {24'h000000, timer_count_high};
            `TMRPO_ADDR_INT_CONTROL: next_rdata = {26'h0, timer_overflow_enable, 2'b00, timer_overflow_flag, 2'b00};
            `TMRPO_ADDR_TIMER_CONTROL: next_rdata = {24'h000000, timer_control};
            `TMRPO_ADDR_IRQ_STATUS: next_rdata = {31'h0, irq_status};
            `TMRPO_ADDR_IRQ_MASK: next_rdata = {31'h0, irq_mask};
            default: next_rdata = 32'h00000000;
        endcase
    end
end

// -----------------------------------------------------------------
// apb answer
// -----------------------------------------------------------------
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        pready <= 1'b0;
        pslverr <= 1'b0;
        prdata <= 32'h00000000;
    end
    else
    begin
        // pready taken from the setup cycle: no wait state, every output registered
        pready <= psel && !penable;
        pslverr <= psel && !penable && !mapped;
        prdata <= next_rdata;
    end
end

endmodule

// >>> testbench/timer_prescaler_overflow_irq_test.sv
// self-checking bench for the overflow timer
`timescale 1ns/1ps
`include "tmrpo_consts.vh"
module timer_prescaler_overflow_irq_test;
logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, count_tick = 1'h0, sleep_mode = 1'h0;
logic [11:0] paddr = 12'h0;
logic [31:0] pwdata = 32'h0, seed = 32'h8a3096d5, rd;
logic er;
wire [31:0] prdata;
wire pready, pslverr, timer_irq, tmr_request;
int num_errors = 0, checks_done = 0, d, r;
localparam logic [11:0] ad_lo = `TMRPO_ADDR_COUNT_LOW, ad_hi = `TMRPO_ADDR_COUNT_HIGH, ad_ic = `TMRPO_ADDR_INT_CONTROL;
localparam logic [11:0] ad_tc = `TMRPO_ADDR_TIMER_CONTROL, ad_st = `TMRPO_ADDR_IRQ_STATUS, ad_mk = `TMRPO_ADDR_IRQ_MASK;
tmrpo_timer tmrpo_timer_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .count_tick(count_tick),
    .sleep_mode(sleep_mode), .timer_irq(timer_irq), .tmr_request(tmr_request));
// ------------------------------
// helpers
// ------------------------------
function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
endfunction
task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
        num_errors++;
        $display("unexpected %s: expected %h seen %h", s, exp, seen);
    end
endtask
task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] v);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, v};
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    // no fixed latency assumed: wait for ready, bounded
    while (pready !== 1'h1 && n < 16)
    begin
        @(posedge pclk);
        n++;
    end
    if (n == 16)
        num_errors++;
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
endtask
task automatic wr(input logic [11:0] a, input logic [7:0] v);
    apb(1'h1, a, v);
endtask
task automatic rc(input string s, input logic [11:0] a, input logic [7:0] e);
    apb(1'h0, a, 8'h0);
    chk(s, rd, {24'h0, e});
endtask
// ticks are seen on k edges, then the count pipeline settles
task automatic tick(input int k);
    count_tick <= 1'h1;
    repeat (k) @(posedge pclk);
    count_tick <= 1'h0;
    repeat (3) @(posedge pclk);
endtask
task automatic conclude();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
        $display("Test passed");
    else
        $display("Test failed");
    $finish;
endtask
// ------------------------------
// clock, watchdog, tests
// ------------------------------
initial
begin
    forever #5 pclk = ~pclk;
end
initial
begin
    #100us;
    num_errors++;
    conclude();
end
initial
begin
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    rc("tctl", ad_tc, `TMRPO_TC_RESET);
    rc("ictl", ad_ic, `TMRPO_IC_RESET);
    apb(1'h0, 12'h0f0, 8'h0);
    chk("slverr", er, 1'h1);
    chk("rdata", rd, 32'h0);
    $display("reset done");
    wr(ad_tc, 8'h08);
    wr(ad_hi, 8'h55);
    wr(ad_lo, 8'hfe);
    wr(ad_mk, 8'h01);
    wr(ad_tc, 8'h88);
    tick(2);
    rc("low", ad_lo, 8'h00);
    rc("high", ad_hi, 8'h55);
    rc("ictl", ad_ic, 8'h04);
    chk("req", tmr_request, 1'h0);
    chk("irq", timer_irq, 1'h1);
    rc("status", ad_st, 8'h01);
    rc("status", ad_st, 8'h00);
    chk("irq", timer_irq, 1'h0);
    wr(ad_ic, 8'h24);
    rc("ictl", ad_ic, 8'h24);
    chk("req", tmr_request, 1'h1);
    wr(ad_ic, 8'h20);
    rc("ictl", ad_ic, 8'h20);
    chk("req", tmr_request, 1'h0);
    $display("8-bit done");
    wr(ad_mk, 8'h00);
    wr(ad_tc, 8'h48);
    wr(ad_hi, 8'h00);
    wr(ad_lo, 8'hff);
    wr(ad_tc, 8'hc8);
    tick(1);
    rc("high", ad_hi, 8'h01);
    rc("ictl", ad_ic, 8'h20);
    wr(ad_hi, 8'hff);
    wr(ad_lo, 8'hff);
    tick(1);
    rc("ictl", ad_ic, 8'h24);
    chk("req", tmr_request, 1'h1);
    chk("irq", timer_irq, 1'h0);
    rc("status", ad_st, 8'h01);
    wr(ad_ic, 8'h00);
    $display("16-bit done");
    // ratio changed while running; random remainder left in the prescaler
    for (int n = 0; n < 8; n++)
    begin
        d = 1 << (n + 1);
        seed = lfsr(seed);
        r = 1 + seed % (d - 1);
        wr(ad_tc, 8'h80 | 8'(n));
        wr(ad_lo, 8'h00);
        tick(2 * d + r);
        rc("low", ad_lo, 8'h02);
        rc("tctl", ad_tc, 8'h80 | 8'(n));
        wr(ad_lo, 8'h10);
        tick(d - 1);
        rc("low", ad_lo, 8'h10);
        tick(1);
        rc("low", ad_lo, 8'h11);
    end
    $display("prescaler done");
    wr(ad_tc, 8'h88);
    wr(ad_lo, 8'hff);
    sleep_mode <= 1'h1;
    tick(4);
    rc("ictl", ad_ic, 8'h00);
    rc("low", ad_lo, 8'hff);
    sleep_mode <= 1'h0;
    wr(ad_tc, 8'h08);
    tick(4);
    rc("low", ad_lo, 8'hff);
    $display("sleep done");
    conclude();
end
endmodule
bind tmrpo_timer tmrpo_monitor tmrpo_monitor_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .count_tick(count_tick), .sleep_mode(sleep_mode), .timer_irq(timer_irq), .tmr_request(tmr_request));

// >>> testbench/tmrpo_monitor.sv
// port checker for the overflow timer
`timescale 1ns/1ps
module tmrpo_monitor
(
    // apb
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // timer
    input wire count_tick,
    input wire sleep_mode,
    input wire timer_irq,
    input wire tmr_request
);
// ------------------------------
// bus and flag relations
// ------------------------------
default clocking cb @(posedge pclk);
endclocking
default disable iff (!presetn);
a_ready_setup: assert property (psel && !penable |=> pready) else $error("ready missing");
a_ready_pulse: assert property (pready |=> !pready) else $error("ready too long");
a_idle_quiet: assert property (!psel |=> !pready && !pslverr) else $error("answer without request");
a_unmapped_err: assert property (psel && !penable && paddr > 12'h014 |=> pslverr && prdata == 0)
    else $error("unmapped access accepted");
// sleep freezes the count, so nothing new may appear
a_sleep_flag:
    assert property (sleep_mode && !psel && !tmr_request |=> !tmr_request) else $error("flag rose in sleep");
a_sleep_irq:
    assert property (sleep_mode && !psel && !timer_irq |=> !timer_irq) else $error("irq rose in sleep");
a_flag_sticky:
    assert property (tmr_request && !psel |=> tmr_request) else $error("request dropped alone");
a_irq_sticky:
    assert property (timer_irq && !psel |=> timer_irq) else $error("irq dropped alone");
endmodule
